/* File: hw/timer_clk_consts.svh */
// constants for the timer clock select and shared prescaler block
// Function
// R01 - select 0 stops, 1 undivided clock, 2..5 prescaler taps 8/64/256/1024
// R02 - select 6 counts falling pin edges, 7 rising, one tick per edge
// R03 - pin edges count even when the pin is driven as an output
// R04 - counter readable and writable; a write blocks the next tick's match
// R05 - compare value checked against counter every tick; equality is a match
// R06 - compare request only when compare enable, global enable, flag all set
// R07 - overflow request only when overflow enable, global enable, flag set
// R08 - compare flag sets on match, clears on vector taken or written one
// R09 - overflow flag sets on overflow, clears on vector taken or written one
// R10 - phase-correct mode sets overflow flag at direction change at zero
// R11 - one prescaler feeds both timers, each with its own select
// R12 - prescaler runs freely, ignoring selects; first count 1..N+1 clocks
// R13 - prescaler reset restarts divider phase for every connected timer
// R14 - pin sampled once per system clock on rising edge
// R15 - pin edge reaches counter 2.5 to 3.5 system clocks later
// R16 - source keeps pin stable one clock around enabling or disabling
// R17 - each pin half period longer than one system clock
// R18 - external pin source bypasses the prescaler
// R19 - writing one to reset bit resets prescaler; bit self-clears, reads zero
// R20 - counter advances only on cycles where the selected tick is high
`ifndef TIMER_CLK_CONSTS_SVH
`define TIMER_CLK_CONSTS_SVH
`define ADDR_COUNT_VALUE 3'h0
`define ADDR_COMPARE_VALUE 3'h1
`define ADDR_IRQ_MASK 3'h2
`define ADDR_IRQ_FLAGS 3'h3
`define ADDR_SFC 3'h4
`define ADDR_CTRL 3'h5
`define BIT_OVF 0
`define BIT_CMP 1
`define BIT_PSR 0
`define CTRL_CS_LSB 0
`define CTRL_CS_B_LSB 3
`define CTRL_PWM_PC 6
`define RST_BYTE 8'h00
`define TAP_8 3
`define TAP_64 6
`define TAP_256 8
`define TAP_1024 10
`define PRESC_W 10
`endif

/* File: hw/timer_clk_pkg.sv */
// types for the timer clock select and shared prescaler block
package timer_clk_pkg;
   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_FALL = 3'h6,
      CS_EXT_RISE = 3'h7
   } clk_sel_e;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;
   typedef struct packed {
      logic overflow;
      logic compare;
   } irq_s;
endpackage : timer_clk_pkg

/* File: hw/timer_clock_select_prescaler.sv */
// timer clock source select, shared prescaler, pin sync and flags
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/100ps
`include "timer_clk_consts.svh"
module timer_clock_select_prescaler #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire timer_clk_pkg::bus_req_s busReq,
   output logic [7:0] rdata_q,
   // external count pins, read back whatever drives them
   input wire logic extCountPin,
   input wire logic extCountPinB,
   // core interface
   input wire logic globalIrqEnable,
   input wire timer_clk_pkg::irq_s vectorTaken,
   output timer_clk_pkg::irq_s irqReq_q,
   // ticks out
   output logic timerTick_q,
   output logic timerTickB_q,
   output logic compareMatch_q,
   output logic [CNT_W-1:0] countValue_q
);
   logic [CNT_W-1:0] compareValue_q;
   logic [1:0] irqMask_q;
   timer_clk_pkg::irq_s flags_q;
   logic [2:0] clockSourceSelect_q;
   logic [2:0] timerSourceSelect_q;
   logic pwmPhaseCorrect_q;
   logic countDown_q;
   logic [`PRESC_W-1:0] presc_q;
   logic prescalerResetStrobe;
   logic [`PRESC_W-1:0] prescPrev_q;
   logic [2:0] syncA_q;
   logic [2:0] syncB_q;
   logic cntWrite_q;
   logic tickA;
   logic tickB;
   logic wrHit;
   logic matchNow;
   logic ovfNow;

   // one tap pulse per divider wrap of the given width
   function automatic logic tapPulse(input logic [`PRESC_W-1:0] cur,
                                     input logic [`PRESC_W-1:0] prev,
                                     input int bits);
      logic r;
      r = 1'b0;
      for (int i = 0; i < `PRESC_W; i++) begin
         if (i == bits - 1) begin
            r = prev[i] & ~cur[i];
         end
      end
      return r;
   endfunction : tapPulse

   // decode a select to its tick; shared by both timers
   function automatic logic selTick(input logic [2:0] sel,
                                    input logic [`PRESC_W-1:0] cur,
                                    input logic [`PRESC_W-1:0] prev,
                                    input logic s1, input logic s2);
      logic t;
      t = 1'b0;
      unique case (timer_clk_pkg::clk_sel_e'(sel))
         timer_clk_pkg::CS_STOP: t = 1'b0; // R01
         timer_clk_pkg::CS_DIV1: t = 1'b1; // R01
         timer_clk_pkg::CS_DIV8: t = tapPulse(cur, prev, `TAP_8); // R01
         timer_clk_pkg::CS_DIV64: t = tapPulse(cur, prev, `TAP_64); // R01
         timer_clk_pkg::CS_DIV256: t = tapPulse(cur, prev, `TAP_256); // R01
         timer_clk_pkg::CS_DIV1024: t = tapPulse(cur, prev, `TAP_1024);
         // pin edges skip the divider
         timer_clk_pkg::CS_EXT_FALL: t = s2 & ~s1; // R02 R18
         timer_clk_pkg::CS_EXT_RISE: t = ~s2 & s1; // R02 R18
      endcase
      return t;
   endfunction : selTick

   assign wrHit = busReq.wr;
   assign prescalerResetStrobe = wrHit && busReq.addr == `ADDR_SFC
                                 && busReq.wdata[`BIT_PSR]; // R19

   // free running divider, blind to both selects
   always_ff @(posedge clk or posedge sys_rst) begin // R12
      if (sys_rst) begin
         presc_q <= '0;
         prescPrev_q <= '0;
      end else if (prescalerResetStrobe) begin
         presc_q <= '0; // R13
         prescPrev_q <= '0;
      end else begin
         presc_q <= presc_q + {{(`PRESC_W-1){1'b0}}, 1'b1};
         prescPrev_q <= presc_q;
      end
   end

   // pin sampled each rising edge; [2] is the edge reference, [0] unread
   always_ff @(posedge clk or posedge sys_rst) begin // R14
      if (sys_rst) begin
         syncA_q <= '0;
         syncB_q <= '0;
      end else begin
         syncA_q <= {syncA_q[1:0], extCountPin}; // R03
         syncB_q <= {syncB_q[1:0], extCountPinB};
      end
   end

   // two sync stages, edge compare and tick register give about 3 clocks
   assign tickA = selTick(clockSourceSelect_q, presc_q, prescPrev_q,
                          syncA_q[1], syncA_q[2]); // R15 R11
   assign tickB = selTick(timerSourceSelect_q, presc_q, prescPrev_q,
                          syncB_q[1], syncB_q[2]); // R11

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timerTick_q <= 1'b0;
         timerTickB_q <= 1'b0;
      end else begin
         timerTick_q <= tickA;
         timerTickB_q <= tickB;
      end
   end

   assign matchNow = timerTick_q && !cntWrite_q
                     && countValue_q == compareValue_q; // R05 R04
   assign ovfNow = timerTick_q && (pwmPhaseCorrect_q
                   ? (countDown_q && countValue_q == CNT_W'(1)) // R10
                   : (countValue_q == {CNT_W{1'b1}})); // R09

   // counter, software write wins over a tick
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         countValue_q <= '0;
         countDown_q <= 1'b0;
      end else if (wrHit && busReq.addr == `ADDR_COUNT_VALUE) begin
         countValue_q <= busReq.wdata[CNT_W-1:0]; // R04
      end else if (timerTick_q) begin // R20
         if (!pwmPhaseCorrect_q) begin
            countValue_q <= countValue_q + CNT_W'(1);
         end else if (countDown_q) begin
            countValue_q <= countValue_q - CNT_W'(1);
            countDown_q <= countValue_q != CNT_W'(1);
         end else begin
            countValue_q <= countValue_q + CNT_W'(1);
            countDown_q <= countValue_q == {{(CNT_W-1){1'b1}}, 1'b0};
         end
      end
   end

   // match mask lasts until the next tick after a count write
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cntWrite_q <= 1'b0;
      end else if (wrHit && busReq.addr == `ADDR_COUNT_VALUE) begin
         cntWrite_q <= 1'b1; // R04
      end else if (timerTick_q) begin
         cntWrite_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         compareMatch_q <= 1'b0;
      end else begin
         compareMatch_q <= matchNow; // R05
      end
   end

   // control registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         compareValue_q <= '0;
         irqMask_q <= '0;
         clockSourceSelect_q <= '0;
         timerSourceSelect_q <= '0;
         pwmPhaseCorrect_q <= 1'b0;
      end else if (wrHit) begin
         if (busReq.addr == `ADDR_COMPARE_VALUE) begin
            compareValue_q <= busReq.wdata[CNT_W-1:0];
         end
         if (busReq.addr == `ADDR_IRQ_MASK) begin
            irqMask_q <= busReq.wdata[1:0];
         end
         if (busReq.addr == `ADDR_CTRL) begin
            clockSourceSelect_q <= busReq.wdata[`CTRL_CS_LSB +: 3];
            timerSourceSelect_q <= busReq.wdata[`CTRL_CS_B_LSB +: 3];
            pwmPhaseCorrect_q <= busReq.wdata[`CTRL_PWM_PC];
         end
      end
   end

   // flags: a set in the clearing cycle wins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_q <= '0;
      end else begin
         if (matchNow) begin
            flags_q.compare <= 1'b1; // R08
         end else if (vectorTaken.compare || (wrHit
                  && busReq.addr == `ADDR_IRQ_FLAGS
                  && busReq.wdata[`BIT_CMP])) begin
            flags_q.compare <= 1'b0; // R08
         end
         if (ovfNow) begin
            flags_q.overflow <= 1'b1; // R09
         end else if (vectorTaken.overflow || (wrHit
                  && busReq.addr == `ADDR_IRQ_FLAGS
                  && busReq.wdata[`BIT_OVF])) begin
            flags_q.overflow <= 1'b0; // R09
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqReq_q <= '0;
      end else begin
         irqReq_q.compare <= irqMask_q[`BIT_CMP] && globalIrqEnable
                             && flags_q.compare; // R06
         irqReq_q.overflow <= irqMask_q[`BIT_OVF] && globalIrqEnable
                              && flags_q.overflow; // R07
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= `RST_BYTE;
      end else if (busReq.rd) begin
         unique case (busReq.addr)
            `ADDR_COUNT_VALUE: rdata_q <= 8'(countValue_q);
            `ADDR_COMPARE_VALUE: rdata_q <= 8'(compareValue_q);
            `ADDR_IRQ_MASK: rdata_q <= {6'h00, irqMask_q};
            // struct order puts overflow on top; the map wants it at bit 0
            `ADDR_IRQ_FLAGS: rdata_q <= {6'h00, flags_q.compare,
                                         flags_q.overflow}; // R08 R09
            `ADDR_SFC: rdata_q <= 8'h00; // R19
            `ADDR_CTRL: rdata_q <= {1'b0, pwmPhaseCorrect_q,
                                    timerSourceSelect_q, clockSourceSelect_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
endmodule : timer_clock_select_prescaler

/* File: verification/ext_count_source.sv */
// external count signal model driving the count pins
`timescale 1ns/100ps
module ext_count_source #(
   parameter int HALF_NS = 10
) (
   // control from the bench
   input wire logic run,
   // count pin
   output logic pin
);
   initial pin = 1'b0;
   // pin stops within one half period after run drops, so it is stable around select changes
   always begin
      wait (run);
      // start off the clock grid so no toggle lands on a sampling edge
      #1;
      while (run) begin
         #(HALF_NS) pin = ~pin;
      end
   end
endmodule : ext_count_source

/* File: verification/timer_clock_select_prescaler_assertions.sv */
// port-level assertions for the timer clock select block
`timescale 1ns/100ps
`include "timer_clk_consts.svh"
module timer_clock_select_prescaler_assertions #(
   parameter int CNT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // watched ports
   input wire timer_clk_pkg::bus_req_s busReq,
   input wire logic [7:0] rdata_q,
   input wire logic globalIrqEnable,
   input wire timer_clk_pkg::irq_s vectorTaken,
   input wire timer_clk_pkg::irq_s irqReq_q,
   input wire logic timerTick_q,
   input wire logic compareMatch_q,
   input wire logic [CNT_W-1:0] countValue_q
);
   logic cntWr;
   logic sfcRd;
   logic blockPend_q;
   assign cntWr = busReq.wr && busReq.addr == `ADDR_COUNT_VALUE;
   assign sfcRd = busReq.rd && busReq.addr == `ADDR_SFC;
   // a count write arms the block until the following tick
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         blockPend_q <= 1'b0;
      else if (cntWr)
         blockPend_q <= 1'b1;
      else if (timerTick_q)
         blockPend_q <= 1'b0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_wrc; $past(cntWr) |-> countValue_q == $past(busReq.wdata);
   endproperty
   a_wrc: assert property (p_wrc) else $error("count write lost");
   property p_blk; blockPend_q && timerTick_q |=> !compareMatch_q;
   endproperty
   a_blk: assert property (p_blk) else $error("match not blocked");
   property p_mt; compareMatch_q |-> $past(timerTick_q); endproperty
   a_mt: assert property (p_mt) else $error("match without tick");
   property p_cgi; irqReq_q.compare |-> $past(globalIrqEnable); endproperty
   a_cgi: assert property (p_cgi) else $error("compare req gated");
   property p_ogi; irqReq_q.overflow |-> $past(globalIrqEnable); endproperty
   a_ogi: assert property (p_ogi) else $error("overflow req gated");
   property p_vec; vectorTaken.compare && !compareMatch_q
      ##1 !compareMatch_q [*2] |-> !irqReq_q.compare; endproperty
   a_vec: assert property (p_vec) else $error("flag not cleared");
   property p_hold; countValue_q != $past(countValue_q)
      |-> $past(timerTick_q) || $past(cntWr); endproperty
   a_hold: assert property (p_hold) else $error("stray count");
   property p_sfc; $past(sfcRd) |-> rdata_q == 8'h00; endproperty
   a_sfc: assert property (p_sfc) else $error("strobe reads one");
endmodule : timer_clock_select_prescaler_assertions

/* File: verification/timer_clock_select_prescaler_test.sv */
// self-checking bench for the timer clock select block
`timescale 1ns/100ps
`include "timer_clk_consts.svh"
module timer_clock_select_prescaler_test;
   logic clk, sys_rst, extRun, globalIrqEnable;
   logic extCountPin, extCountPinB, timerTick_q, timerTickB_q;
   logic compareMatch_q;
   logic [7:0] rdata_q, countValue_q;
   timer_clk_pkg::bus_req_s busReq;
   timer_clk_pkg::irq_s vectorTaken, irqReq_q;
   int mismatches, compares, tA, tB, rises, falls;
   assign extCountPinB = extCountPin;
   ext_count_source u_ext_count_source (.run(extRun), .pin(extCountPin));
   timer_clock_select_prescaler u_timer_clock_select_prescaler (
      .clk, .sys_rst, .busReq, .rdata_q, .extCountPin, .extCountPinB,
      .globalIrqEnable, .vectorTaken, .irqReq_q, .timerTick_q,
      .timerTickB_q, .compareMatch_q, .countValue_q);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      tA += timerTick_q;
      tB += timerTickB_q;
   end
   always @(posedge extCountPin) rises++;
   always @(negedge extCountPin) falls++;
   task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s exp %0h seen %0h", n, exp, seen);
      end
   endtask : check
   // one idle cycle after each access keeps the strobes single-driven
   task automatic rw(logic w, logic [2:0] a, logic [7:0] d);
      busReq <= '{a, d, w, ~w};
      @(posedge clk);
      busReq <= '0;
      #1;
      if (!w) check("rdata", rdata_q, d);
      @(posedge clk);
   endtask : rw
   task automatic t_div;
      int dv[6] = '{0, 1, 8, 64, 256, 1024};
      int a0, b0;
      for (int s = 0; s < 6; s++) begin
         rw(1, `ADDR_CTRL, {2'b00, 3'(5 - s), 3'(s)});
         #1;
         a0 = tA;
         b0 = tB;
         repeat (2048) @(posedge clk);
         #1;
         check("tickA", tA - a0, dv[s] ? 2048 / dv[s] : 0);
         check("tickB", tB - b0, dv[5-s] ? 2048 / dv[5-s] : 0);
      end
   endtask : t_div
   task automatic t_psr;
      int lat[2];
      rw(1, `ADDR_CTRL, 8'h12);
      for (int k = 0; k < 2; k++) begin
         repeat (k + 3) @(posedge clk);
         rw(1, `ADDR_SFC, 8'h01);
         lat[k] = 0;
         // look after the edge so a tick from the old phase is not seen
         #1;
         while (timerTick_q !== 1'b1 && lat[k] < 20) begin
            @(posedge clk);
            #1;
            lat[k]++;
         end
         check("tickB", timerTickB_q, 1'b1);
      end
      check("psrLat", lat[1], lat[0]);
      check("firstTick", lat[0] <= 8, 1'b1);
   endtask : t_psr
   task automatic t_ext;
      int r0, f0, a0, b0;
      rw(1, `ADDR_CTRL, 8'h37);
      rw(1, `ADDR_COUNT_VALUE, 8'h00);
      r0 = rises;
      f0 = falls;
      a0 = tA;
      b0 = tB;
      extRun <= 1'b1;
      repeat (40) @(posedge clk);
      extRun <= 1'b0;
      repeat (12) @(posedge clk);
      check("extRise", tA - a0, rises - r0);
      check("extFall", tB - b0, falls - f0);
      rw(0, `ADDR_COUNT_VALUE, 8'(rises - r0));
   endtask : t_ext
   task automatic t_cmp;
      rw(1, `ADDR_CTRL, 8'h00);
      rw(1, `ADDR_IRQ_FLAGS, 8'h03);
      rw(1, `ADDR_COMPARE_VALUE, 8'h10);
      rw(0, `ADDR_COMPARE_VALUE, 8'h10);
      rw(1, `ADDR_IRQ_MASK, 8'h03);
      globalIrqEnable <= 1'b1;
      rw(1, `ADDR_COUNT_VALUE, 8'h0C);
      rw(1, `ADDR_CTRL, 8'h01);
      repeat (8) @(posedge clk);
      rw(1, `ADDR_CTRL, 8'h00);
      rw(0, `ADDR_IRQ_FLAGS, 8'h02);
      check("cmpReq", irqReq_q.compare, 1'b1);
      globalIrqEnable <= 1'b0;
      repeat (2) @(posedge clk);
      check("cmpReqOff", irqReq_q.compare, 1'b0);
      globalIrqEnable <= 1'b1;
      rw(1, `ADDR_IRQ_FLAGS, 8'h02);
      rw(0, `ADDR_IRQ_FLAGS, 8'h00);
      rw(1, `ADDR_COUNT_VALUE, 8'hFA);
      rw(1, `ADDR_CTRL, 8'h01);
      repeat (8) @(posedge clk);
      rw(1, `ADDR_CTRL, 8'h00);
      rw(0, `ADDR_IRQ_FLAGS, 8'h01);
      check("ovfReq", irqReq_q.overflow, 1'b1);
      vectorTaken <= 2'b11;
      @(posedge clk);
      vectorTaken <= '0;
      rw(0, `ADDR_IRQ_FLAGS, 8'h00);
      rw(1, `ADDR_CTRL, 8'h01);
      rw(1, `ADDR_COUNT_VALUE, 8'h10);
      rw(1, `ADDR_CTRL, 8'h00);
      rw(0, `ADDR_IRQ_FLAGS, 8'h00);
   endtask : t_cmp
   task automatic t_pc;
      rw(1, `ADDR_CTRL, 8'h40);
      rw(1, `ADDR_COUNT_VALUE, 8'hFC);
      rw(1, `ADDR_CTRL, 8'h41);
      repeat (8) @(posedge clk);
      rw(1, `ADDR_CTRL, 8'h40);
      // turning at the top must not raise the overflow flag
      rw(0, `ADDR_IRQ_FLAGS, 8'h00);
      rw(0, `ADDR_COUNT_VALUE, 8'hF8);
      rw(1, `ADDR_COUNT_VALUE, 8'h03);
      rw(1, `ADDR_CTRL, 8'h41);
      repeat (8) @(posedge clk);
      rw(1, `ADDR_CTRL, 8'h40);
      rw(0, `ADDR_IRQ_FLAGS, 8'h01);
      rw(0, `ADDR_COUNT_VALUE, 8'h07);
   endtask : t_pc
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   initial begin
      sys_rst = 1'b1;
      busReq = '0;
      vectorTaken = '0;
      globalIrqEnable = 1'b0;
      extRun = 1'b0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rw(0, `ADDR_IRQ_MASK, 8'h00);
      rw(1, `ADDR_SFC, 8'h01);
      rw(0, `ADDR_SFC, 8'h00);
      rw(1, `ADDR_COUNT_VALUE, 8'h3C);
      rw(0, `ADDR_COUNT_VALUE, 8'h3C);
      rw(0, 3'h7, 8'h00);
      t_div();
      t_psr();
      t_ext();
      t_cmp();
      t_pc();
      close_out();
   end
   // the whole run needs about 13000 clocks
   initial begin
      #200000;
      mismatches++;
      close_out();
   end
endmodule : timer_clock_select_prescaler_test
bind timer_clock_select_prescaler timer_clock_select_prescaler_assertions
   #(.CNT_W(CNT_W)) u_timer_clock_select_prescaler_assertions (.clk,
   .sys_rst, .busReq, .rdata_q, .globalIrqEnable, .vectorTaken, .irqReq_q,
   .timerTick_q, .compareMatch_q, .countValue_q);
